//--- rtl/ccic_consts.vh
// ccic_consts.vh: command codes, table layout and field positions of the
// counter compare and interrupt control unit; definitions only.
`ifndef CCIC_CONSTS_VH
`define CCIC_CONSTS_VH

// =====================================================================
// mode control codes
`define CCIC_MC_START      16'h0000
`define CCIC_MC_STOP       16'h0001
`define CCIC_MC_LOAD_PV    16'h0002
`define CCIC_MC_LOAD_RMAX  16'h0006

// =====================================================================
// table registration codes
`define CCIC_TB_TGT_START  16'h0000
`define CCIC_TB_FIX_START  16'h0001
`define CCIC_TB_TGT        16'h0002
`define CCIC_TB_FIX        16'h0003
`define CCIC_TB_VAR_START  16'h0004
`define CCIC_TB_VAR        16'h0005

// =====================================================================
// table layout
`define CCIC_FIX_RANGES    4'h8
`define CCIC_TGT_WORDS     3'h3
`define CCIC_RNG_WORDS     3'h5
`define CCIC_TGT_CTL_FLD   3'h2
`define CCIC_RNG_CTL_FLD   3'h4
`define CCIC_TASK_DISABLE  16'hffff
`define CCIC_DIR_BIT       15
`define CCIC_TASK_MSB      7

`endif

//--- rtl/ccic_core.v
// ccic_core.v: comparison and mode control for four pulse counters.
// assumes one controller clock, a scan tick once per controller cycle and
// encoder pulse pins that are asynchronous to i_clk.
`timescale 1ns/1ps
`include "ccic_consts.vh"

module ccic_core #(
    parameter ENTRIES = 8
) (
    input  wire                   i_clk,
    input  wire                   i_srst,
    input  wire [3:0]             i_pulse_up,
    input  wire [3:0]             i_pulse_down,
    input  wire [3:0]             i_ring_mode,
    input  wire                   i_irq_enable,
    input  wire                   i_scan_tick,
    input  wire                   i_mode_cmd_valid,
    input  wire [1:0]             i_mode_cmd_counter,
    input  wire [15:0]            i_mode_cmd_code,
    input  wire [31:0]            i_mode_cmd_value,
    input  wire                   i_tbl_cmd_valid,
    input  wire [1:0]             i_tbl_cmd_counter,
    input  wire [15:0]            i_tbl_cmd_code,
    input  wire                   i_tbl_word_valid,
    input  wire [15:0]            i_tbl_word,
    input  wire                   i_task_done,
    output wire                   o_tbl_ready,
    output reg  [127:0]           o_present_count_value,
    output reg  [4*ENTRIES-1:0]   o_in_range,
    output reg  [3:0]             o_compare_running,
    output reg                    o_irq_req,
    output reg  [7:0]             o_irq_task,
    output reg  [1:0]             o_irq_counter,
    output reg                    o_cyclic_suspend
);
    localparam NE = 4 * ENTRIES, IW = $clog2(NE), EW = $clog2(ENTRIES);
    localparam LD_IDLE = 2'd0, LD_COUNT = 2'd1, LD_BODY = 2'd2;

    // table storage, five flat arrays indexed by {counter, entry}
    reg [15:0]     tb_lo_l [0:NE-1];
    reg [15:0]     tb_lo_h [0:NE-1];
    reg [15:0]     tb_hi_l [0:NE-1];
    reg [15:0]     tb_hi_h [0:NE-1];
    reg [15:0]     tb_ctl  [0:NE-1];
    reg [NE-1:0]   ent_valid;
    reg [3:0]      is_range;
    reg [NE-1:0]   armed;
    reg [NE-1:0]   pending;
    reg [31:0]     pv [0:3];
    reg [31:0]     rmax [0:3];
    reg [3:0]      dir_down;

    // =================================================================
    // pulse pin synchronisers, a rising change counts once stages 2 and 3 agree
    reg [3:0] up_s1, up_s2, up_s3, up_lvl;
    reg [3:0] dn_s1, dn_s2, dn_s3, dn_lvl;
    always @(posedge i_clk) begin
        up_s1 <= i_pulse_up;
        up_s2 <= up_s1;
        up_s3 <= up_s2;
        dn_s1 <= i_pulse_down;
        dn_s2 <= dn_s1;
        dn_s3 <= dn_s2;
        if (i_srst) begin
            up_lvl <= 4'h0;
            dn_lvl <= 4'h0;
        end else begin
            up_lvl <= ((up_s2 ~^ up_s3) & up_s3) | ((up_s2 ^ up_s3) & up_lvl);  // per pin, held while stages differ
            dn_lvl <= ((dn_s2 ~^ dn_s3) & dn_s3) | ((dn_s2 ^ dn_s3) & dn_lvl);
        end
    end
    wire [3:0] up_step = (up_s2 ~^ up_s3) & up_s3 & ~up_lvl;
    wire [3:0] dn_step = (dn_s2 ~^ dn_s3) & dn_s3 & ~dn_lvl;
    wire       mc_pv   = i_mode_cmd_valid && (i_mode_cmd_code == `CCIC_MC_LOAD_PV);
    wire       mc_rmax = i_mode_cmd_valid && (i_mode_cmd_code == `CCIC_MC_LOAD_RMAX);

    // =================================================================
    // counters with ring wrap and command loads
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cnt
            always @(posedge i_clk) begin
                if (i_srst) begin
                    pv[g]       <= 32'h0000_0000;
                    rmax[g]     <= 32'hffff_ffff;
                    dir_down[g] <= 1'b0;
                end else begin
                    if (mc_pv && i_mode_cmd_counter == g)
                        pv[g] <= i_mode_cmd_value;
                    else if (up_step[g] && !dn_step[g]) begin
                        dir_down[g] <= 1'b0;
                        pv[g] <= (i_ring_mode[g] && pv[g] >= rmax[g]) ? 32'h0000_0000 : pv[g] + 32'h1;
                    end else if (dn_step[g] && !up_step[g]) begin
                        dir_down[g] <= 1'b1;
                        pv[g] <= (i_ring_mode[g] && pv[g] == 32'h0) ? rmax[g] : pv[g] - 32'h1;
                    end
                    if (mc_rmax && i_mode_cmd_counter == g)
                        rmax[g] <= i_mode_cmd_value;
                end
            end
            always @(posedge i_clk) begin
                o_present_count_value[32*g+31:32*g] <= i_srst ? 32'h0 : pv[g];
            end
        end
    endgenerate

    // =================================================================
    // table loader: words stream in after a registration command
    reg  [1:0]    ld_state;
    reg  [1:0]    ld_cnt;
    reg           ld_range;
    reg           ld_start;
    reg  [EW:0]   ld_left;
    reg  [EW-1:0] ld_ent;
    reg  [2:0]    ld_fld;
    wire [IW-1:0] ld_idx = {ld_cnt, ld_ent};
    wire [2:0]    ld_last = ld_range ? `CCIC_RNG_WORDS - 3'h1 : `CCIC_TGT_WORDS - 3'h1;
    wire          ld_fix = (i_tbl_cmd_code == `CCIC_TB_FIX) || (i_tbl_cmd_code == `CCIC_TB_FIX_START);
    wire          ld_tgt = (i_tbl_cmd_code == `CCIC_TB_TGT) || (i_tbl_cmd_code == `CCIC_TB_TGT_START);
    assign o_tbl_ready = (ld_state == LD_IDLE);
    // loader state machine and table writes
    always @(posedge i_clk) begin
        if (i_srst) begin
            ld_state  <= LD_IDLE;
            ld_cnt    <= 2'h0;
            ld_range  <= 1'b0;
            ld_start  <= 1'b0;
            ld_left   <= {(EW+1){1'b0}};
            ld_ent    <= {EW{1'b0}};
            ld_fld    <= 3'h0;
            is_range  <= 4'h0;
            ent_valid <= {NE{1'b0}};
        end else begin
            case (ld_state)
                LD_IDLE: begin
                    if (i_tbl_cmd_valid) begin
                        ld_cnt   <= i_tbl_cmd_counter;
                        ld_range <= !ld_tgt;
                        ld_start <= (i_tbl_cmd_code == `CCIC_TB_TGT_START) || (i_tbl_cmd_code == `CCIC_TB_FIX_START)
                                    || (i_tbl_cmd_code == `CCIC_TB_VAR_START);
                        ld_ent   <= {EW{1'b0}};
                        ld_fld   <= 3'h0;
                        ld_left  <= `CCIC_FIX_RANGES;
                        ld_state <= ld_fix ? LD_BODY : LD_COUNT;
                        ent_valid[{i_tbl_cmd_counter, {EW{1'b0}}} +: ENTRIES] <= {ENTRIES{1'b0}};
                    end
                end
                LD_COUNT: begin
                    if (i_tbl_word_valid) begin
                        ld_left  <= (i_tbl_word > ENTRIES) ? ENTRIES[EW:0] : i_tbl_word[EW:0];
                        ld_state <= (i_tbl_word == 16'h0) ? LD_IDLE : LD_BODY;
                    end
                end
                LD_BODY: begin
                    if (i_tbl_word_valid) begin
                        case (ld_fld)
                            3'h0: tb_lo_l[ld_idx] <= i_tbl_word;
                            3'h1: tb_lo_h[ld_idx] <= i_tbl_word;
                            3'h2: if (ld_range) tb_hi_l[ld_idx] <= i_tbl_word; else tb_ctl[ld_idx] <= i_tbl_word;
                            3'h3: tb_hi_h[ld_idx] <= i_tbl_word;
                            default: tb_ctl[ld_idx] <= i_tbl_word;
                        endcase
                        if (ld_fld == ld_last) begin
                            ld_fld <= 3'h0;
                            ld_ent <= ld_ent + {{(EW-1){1'b0}}, 1'b1};
                            ld_left <= ld_left - {{EW{1'b0}}, 1'b1};
                            ent_valid[ld_idx] <= !(ld_range && i_tbl_word == `CCIC_TASK_DISABLE);
                            if (ld_left == {{EW{1'b0}}, 1'b1 }) begin
                                ld_state <= LD_IDLE;
                                is_range[ld_cnt] <= ld_range;
                            end
                        end else begin
                            ld_fld <= ld_fld + 3'h1;
                        end
                    end
                end
                default: ld_state <= LD_IDLE;
            endcase
        end
    end
    wire ld_done = (ld_state == LD_BODY) && i_tbl_word_valid && (ld_fld == ld_last)
                   && (ld_left == {{EW{1'b0}}, 1'b1});
    // =================================================================
    // run control: start, stop and start-on-registration
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_compare_running <= 4'h0;
        end else begin
            if (ld_done && ld_start && i_irq_enable)
                o_compare_running[ld_cnt] <= 1'b1;
            else if (i_mode_cmd_valid && i_mode_cmd_code == `CCIC_MC_START)
                o_compare_running[i_mode_cmd_counter] <= 1'b1;
            else if (i_mode_cmd_valid && i_mode_cmd_code == `CCIC_MC_STOP)
                o_compare_running[i_mode_cmd_counter] <= 1'b0;
        end
    end

    // =================================================================
    // scan: one entry per clock, every entry once per controller cycle
    reg  [IW-1:0] sc_idx;
    reg           sc_busy;
    wire [1:0]    sc_cnt  = sc_idx[IW-1:EW];
    wire [31:0]   sc_pv   = pv[sc_cnt];
    wire [31:0]   sc_lo   = {tb_lo_h[sc_idx], tb_lo_l[sc_idx]};
    wire [31:0]   sc_hi   = {tb_hi_h[sc_idx], tb_hi_l[sc_idx]};
    wire          sc_dir  = tb_ctl[sc_idx][`CCIC_DIR_BIT];
    wire          ld_busy_cnt = (ld_state != LD_IDLE) && (ld_cnt == sc_cnt);
    wire          sc_live = sc_busy && ent_valid[sc_idx] && o_compare_running[sc_cnt] && !ld_busy_cnt;
    wire          sc_in   = (sc_pv >= sc_lo) && (sc_pv <= sc_hi);
    wire          sc_eq   = (sc_pv == sc_lo);
    reg           sc_fire;
    // event of the entry under scan
    always @* begin
        sc_fire = 1'b0;
        if (sc_live) begin
            if (is_range[sc_cnt])
                sc_fire = sc_dir ? (!sc_in && o_in_range[sc_idx])
                                 : (sc_in && !o_in_range[sc_idx]);
            else
                sc_fire = sc_eq && armed[sc_idx] && (sc_dir == dir_down[sc_cnt]);
        end
    end
    // scan walk, in-range flags and target re-arm
    always @(posedge i_clk) begin
        if (i_srst) begin
            sc_idx     <= {IW{1'b0}};
            sc_busy    <= 1'b0;
            o_in_range <= {NE{1'b0}};
            armed      <= {NE{1'b1}};
        end else begin
            if (i_scan_tick && !sc_busy)
                sc_busy <= 1'b1;
            else if (sc_busy && sc_idx == NE[IW-1:0] - {{(IW-1){1'b0}}, 1'b1})
                sc_busy <= 1'b0;
            if (sc_busy) begin
                sc_idx <= sc_idx + {{(IW-1){1'b0}}, 1'b1};
                o_in_range[sc_idx] <= sc_live && is_range[sc_cnt] && sc_in;
                armed[sc_idx] <= !(sc_live && sc_eq);                   // fire once per arrival
            end
        end
    end

    // =================================================================
    // pending tasks, lowest table position served first
    reg [IW-1:0] pick;
    reg          pick_ok;
    integer      k;
    always @* begin
        pick    = {IW{1'b0}};
        pick_ok = 1'b0;
        for (k = NE - 1; k >= 0; k = k - 1) begin
            if (pending[k]) begin
                pick    = k[IW-1:0];
                pick_ok = 1'b1;
            end
        end
    end
    // interrupt request and suspension of cyclic work
    always @(posedge i_clk) begin
        if (i_srst) begin
            pending          <= {NE{1'b0}};
            o_irq_req        <= 1'b0;
            o_irq_task       <= 8'h00;
            o_irq_counter    <= 2'h0;
            o_cyclic_suspend <= 1'b0;
        end else begin
            o_irq_req <= 1'b0;
            if (o_cyclic_suspend) begin
                if (i_task_done)
                    o_cyclic_suspend <= 1'b0;
            end else if (pick_ok && i_irq_enable) begin
                pending[pick]    <= 1'b0;
                o_irq_req        <= 1'b1;
                o_irq_task       <= tb_ctl[pick][`CCIC_TASK_MSB:0];
                o_irq_counter    <= pick[IW-1:EW];
                o_cyclic_suspend <= 1'b1;
            end
            if (sc_fire)
                pending[sc_idx] <= 1'b1;                                // set wins over the serve clear
        end
    end
endmodule // ccic_core

//--- dv/ccic_core_checker.sv
// ccic_core_checker: command, loader and interrupt timing seen at the ports.
// assumes one clock i_clk and the synchronous reset i_srst; attached by bind.
`timescale 1ns/1ps
module ccic_core_checker #(
    parameter ENTRIES = 8
) (
    input wire         i_clk,
    input wire         i_srst,
    input wire         i_irq_enable,
    input wire         i_mode_cmd_valid,
    input wire [1:0]   i_mode_cmd_counter,
    input wire [15:0]  i_mode_cmd_code,
    input wire [31:0]  i_mode_cmd_value,
    input wire         i_tbl_cmd_valid,
    input wire         i_task_done,
    input wire         o_tbl_ready,
    input wire [127:0] o_present_count_value,
    input wire [3:0]   o_compare_running,
    input wire         o_irq_req,
    input wire         o_cyclic_suspend
);
    // ==============================================================
    // clocking and a loader-idle helper
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire idle = o_tbl_ready && !i_tbl_cmd_valid;  // no start-on-registration can race
    // ==============================================================
    // mode commands
    a_load_count: assert property (i_mode_cmd_valid && i_mode_cmd_code == 16'h0002 |-> ##2
        o_present_count_value[32*$past(i_mode_cmd_counter, 2) +: 32] == $past(i_mode_cmd_value, 2))
        else $error("loaded count not shown two cycles later");
    a_start_runs: assert property (i_mode_cmd_valid && i_mode_cmd_code == 16'h0000 && idle
        |=> o_compare_running[$past(i_mode_cmd_counter)]) else $error("start did not run");
    a_stop_halts: assert property (i_mode_cmd_valid && i_mode_cmd_code == 16'h0001 && idle
        |=> !o_compare_running[$past(i_mode_cmd_counter)]) else $error("stop did not halt");
    a_other_code: assert property (i_mode_cmd_valid && i_mode_cmd_code > 16'h0001 && idle
        |=> $stable(o_compare_running)) else $error("non start code changed running");
    // ==============================================================
    // loader and interrupt handshake
    a_tbl_busy: assert property (i_tbl_cmd_valid && o_tbl_ready |=> !o_tbl_ready)
        else $error("loader did not go busy");
    a_irq_single: assert property (o_irq_req |=> !o_irq_req [*2])
        else $error("request longer than one cycle");
    a_irq_suspends: assert property (o_irq_req |-> o_cyclic_suspend && $past(i_irq_enable))
        else $error("request without suspend");
    a_suspend_holds: assert property (o_cyclic_suspend && !i_task_done |=> o_cyclic_suspend)
        else $error("suspend dropped early");
    a_suspend_ends: assert property (o_cyclic_suspend && i_task_done |=> !o_cyclic_suspend)
        else $error("suspend kept after done");
    // main scenarios reached
    c_irq: cover property (o_irq_req);
    c_load: cover property (i_tbl_cmd_valid && o_tbl_ready);
    c_resume: cover property (o_cyclic_suspend && i_task_done);
endmodule  // ccic_core_checker

bind ccic_core ccic_core_checker #(.ENTRIES(ENTRIES)) ccic_core_checker_inst (.i_clk, .i_srst, .i_irq_enable,
    .i_mode_cmd_valid, .i_mode_cmd_counter, .i_mode_cmd_code, .i_mode_cmd_value, .i_tbl_cmd_valid,
    .i_task_done, .o_tbl_ready, .o_present_count_value, .o_compare_running, .o_irq_req, .o_cyclic_suspend);

//--- dv/ccic_ctrl_model.sv
// ccic_ctrl_model: controller side that runs one interrupt task per request.
// assumes i_task_len of at least one cycle; done is a one-cycle pulse.
`timescale 1ns/1ps
module ccic_ctrl_model (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_irq_req,
    input  wire [7:0] i_task_len,
    output reg        o_task_done
);
    reg [7:0] left;  // task cycles still to run, zero when idle
    // start a task on request, report done in the cycle after its last
    always @(posedge i_clk) begin
        o_task_done <= 1'b0;
        if (i_srst) begin
            left <= 8'h00;
        end else if (i_irq_req) begin
            left <= i_task_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
            o_task_done <= (left == 8'h01);
        end
    end
endmodule  // ccic_ctrl_model

//--- dv/ccic_core_test.sv
// ccic_core_test: mode rows in a loop, then ring, target, range and reset.
// assumes ccic_core, its checker and ccic_ctrl_model are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module ccic_core_test;
    reg          i_clk = 1'b0;
    reg          i_srst = 1'b1;
    reg  [3:0]   p_up = 4'h0;
    reg  [3:0]   p_dn = 4'h0;
    reg          tick = 1'b0;
    reg          m_vld = 1'b0;
    reg  [1:0]   m_ctr = 2'h0;
    reg  [15:0]  m_code = 16'h0000;
    reg  [31:0]  m_val = 32'h00000000;
    reg          t_vld = 1'b0;
    reg  [1:0]   t_ctr = 2'h0;
    reg  [15:0]  t_code = 16'h0000;
    reg          w_vld = 1'b0;
    reg  [15:0]  w_dat = 16'h0000;
    reg  [7:0]   task_len = 8'h14;
    reg          hit;
    reg          irq_en = 1'b1;
    wire         done;
    wire         rdy;
    wire [127:0] pv;
    wire [31:0]  rng;
    wire [3:0]   run;
    wire         irq;
    wire [7:0]   tsk;
    wire [1:0]   ictr;
    wire         susp;
    int          miscompares = 0;
    int          check_count = 0;
    int          i;
    // rows: counter, code, value, expected count, expected running
    reg  [1:0]   r_ctr [0:5] = '{0, 3, 3, 3, 3, 2};
    reg  [15:0]  r_code [0:5] = '{2, 2, 3, 0, 1, 2};
    reg  [31:0]  r_val [0:5] = '{8, 32'h12345678, 1, 99, 7, 0};
    reg  [31:0]  r_pv [0:5] = '{8, 32'h12345678, 32'h12345678, 32'h12345678, 32'h12345678, 0};
    reg          r_run [0:5] = '{0, 0, 0, 1, 0, 0};
    reg  [15:0]  tgt [0:6] = '{2, 10, 0, 16'h000a, 9, 0, 16'h800b};
    reg  [15:0]  rtab [0:9] = '{20, 0, 30, 0, 16'h000c, 0, 0, 100, 0, 16'hffff};
    // 20 MHz clock
    always #25 i_clk = ~i_clk;
    // ring mode on counter 1 only, interrupts enabled except in the start gate test
    ccic_core #(.ENTRIES(8)) ccic_core_inst (.i_clk(i_clk), .i_srst(i_srst), .i_pulse_up(p_up),
        .i_pulse_down(p_dn), .i_ring_mode(4'h2), .i_irq_enable(irq_en), .i_scan_tick(tick),
        .i_mode_cmd_valid(m_vld), .i_mode_cmd_counter(m_ctr), .i_mode_cmd_code(m_code),
        .i_mode_cmd_value(m_val), .i_tbl_cmd_valid(t_vld), .i_tbl_cmd_counter(t_ctr),
        .i_tbl_cmd_code(t_code), .i_tbl_word_valid(w_vld), .i_tbl_word(w_dat), .i_task_done(done),
        .o_tbl_ready(rdy), .o_present_count_value(pv), .o_in_range(rng), .o_compare_running(run),
        .o_irq_req(irq), .o_irq_task(tsk), .o_irq_counter(ictr), .o_cyclic_suspend(susp));
    ccic_ctrl_model ccic_ctrl_model_inst (.i_clk(i_clk), .i_srst(i_srst), .i_irq_req(irq),
        .i_task_len(task_len), .o_task_done(done));
    // ==============================================================
    // drivers, all changing at the falling edge
    task automatic mode(input [1:0] c, input [15:0] k, input [31:0] v);
        {m_vld, m_ctr, m_code, m_val} = {1'b1, c, k, v};
        @(negedge i_clk) m_vld = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask
    task automatic tcmd(input [1:0] c, input [15:0] k);
        {t_vld, t_ctr, t_code} = {1'b1, c, k};
        @(negedge i_clk) t_vld = 1'b0;
    endtask
    task automatic word(input [15:0] w);
        {w_vld, w_dat} = {1'b1, w};
        @(negedge i_clk);
    endtask
    task automatic pulse(input [3:0] u, input [3:0] d);
        {p_up, p_dn} = {u, d};
        repeat (3) @(negedge i_clk);
        {p_up, p_dn} = 8'h00;
        repeat (6) @(negedge i_clk);
    endtask
    // one scan; stops at the first request, a missing expected one ends the run
    task automatic scan(input exp);
        int j;
        hit = 1'b0;
        tick = 1'b1;
        @(negedge i_clk) tick = 1'b0;
        for (j = 0; j < 60 && !hit; j++) begin
            hit = (irq === 1'b1);
            if (!hit) @(negedge i_clk);
        end
        if (exp && !hit) begin
            miscompares++;
            $display("unexpected at %0t: no request", $time);
            end_sim();
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==============================================================
    // main sequence
    initial begin
        repeat (16) @(negedge i_clk);
        i_srst = 1'b0;
        for (i = 0; i < 6; i++) begin
            mode(r_ctr[i], r_code[i], r_val[i]);
            `CHK(pv[32*r_ctr[i] +: 32], r_pv[i])
            `CHK(run[r_ctr[i]], r_run[i])
        end
        $display("mode rows done");
        mode(2'h1, 16'h0006, 32'h5);
        mode(2'h1, 16'h0002, 32'h5);
        pulse(4'h2, 4'h0);
        `CHK(pv[63:32], 32'h0)
        pulse(4'h0, 4'h2);
        `CHK(pv[63:32], 32'h5)
        $display("ring done");
        tcmd(2'h0, 16'h0000);
        for (i = 0; i < 7; i++) word(tgt[i]);
        w_vld = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK(run[0], 1'b1)
        pulse(4'h1, 4'h0);
        pulse(4'h1, 4'h0);
        scan(1'b1);
        `CHK({hit, ictr, tsk, susp}, 12'h815)
        repeat (10) @(negedge i_clk);
        `CHK(susp, 1'b1)
        repeat (15) @(negedge i_clk);
        `CHK(susp, 1'b0)
        pulse(4'h0, 4'h1);
        scan(1'b1);
        `CHK({hit, ictr, tsk}, 11'h40b)
        $display("target done");
        task_len = 8'h01;
        tcmd(2'h2, 16'h0001);
        for (i = 0; i < 40; i++) word(i < 10 ? rtab[i] : (i % 5 == 4 ? 16'hffff : 16'h0000));
        w_vld = 1'b0;
        mode(2'h2, 16'h0002, 32'd25);
        scan(1'b1);
        `CHK({hit, ictr, tsk}, 11'h60c)
        repeat (40) @(negedge i_clk);
        `CHK(rng[17:16], 2'b01)
        scan(1'b0);
        `CHK(hit, 1'b0)
        mode(2'h2, 16'h0002, 32'd40);
        scan(1'b0);
        `CHK({hit, rng[16]}, 2'b00)
        $display("range done");
        irq_en = 1'b0;
        tcmd(2'h3, 16'h0000);
        for (i = 0; i < 4; i++) word(i == 0 ? 16'h0001 : 16'h0000);
        w_vld = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK({run[3], rdy}, 2'b01)
        irq_en = 1'b1;
        $display("start gate done");
        i_srst = 1'b1;
        repeat (2) @(negedge i_clk);
        `CHK({pv, run, rdy, susp}, {128'h0, 4'h0, 1'b1, 1'b0})
        i_srst = 1'b0;
        $display("reset done");
        end_sim();
    end
endmodule  // ccic_core_test
